// ### dv/mac_ind_regs_props.sv
// Checker of the station address and indirect command ports
// Assumes a bind onto mac_ind_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none

module mac_ind_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [47:0] station_address,
    input wire logic        cmd_valid,
    input wire logic        cmd_read,
    input wire logic [11:0] cmd_addr,
    input wire logic        tbl_rdone,
    input wire logic        busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ********
    // Properties
    // ********
    property p_sa_top;
        reg_wr && reg_addr == 8'h68 |-> ##2 station_address[47:40] == $past(reg_wdata, 2);
    endproperty
    property p_sa_low;
        reg_wr && reg_addr == 8'h6D |-> ##2 station_address[7:0] == $past(reg_wdata, 2);
    endproperty
    property p_rd_ctrl1;
        reg_wr && reg_addr == 8'h6F ##1 reg_rd && reg_addr == 8'h6F
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_only_trig;
        !(reg_wr && reg_addr == 8'h6F) |=> !cmd_valid;
    endproperty
    property p_cmd_addr;
        cmd_valid |-> cmd_addr[7:0] == $past(reg_wdata);
    endproperty
    property p_read_busy;
        cmd_valid && cmd_read |-> busy;
    endproperty
    property p_write_idle;
        cmd_valid && !cmd_read |-> !busy;
    endproperty
    property p_busy_end;
        busy && tbl_rdone |=> !busy;
    endproperty
    property p_busy_block;
        busy && reg_wr && reg_addr == 8'h6F |=> !cmd_valid;
    endproperty

    a_sa_top: assert property (p_sa_top) else $error("top address byte wrong");
    a_sa_low: assert property (p_sa_low) else $error("low address byte wrong");
    a_rd_ctrl1: assert property (p_rd_ctrl1) else $error("ctrl1 readback wrong");
    a_only_trig: assert property (p_only_trig) else $error("command without trigger");
    a_cmd_addr: assert property (p_cmd_addr) else $error("command low address wrong");
    a_read_busy: assert property (p_read_busy) else $error("read not busy");
    a_write_idle: assert property (p_write_idle) else $error("write made busy");
    a_busy_end: assert property (p_busy_end) else $error("busy not released");
    a_busy_block: assert property (p_busy_block) else $error("trigger taken while busy");

    c_read: cover property (cmd_valid && cmd_read);
    c_write: cover property (cmd_valid && !cmd_read);
    c_block: cover property (busy && reg_wr && reg_addr == 8'h6F);
endmodule

bind mac_ind_regs mac_ind_checker chk_i (
    .clock          (clock),
    .rst_n          (rst_n),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .station_address(station_address),
    .cmd_valid      (cmd_valid),
    .cmd_read       (cmd_read),
    .cmd_addr       (cmd_addr),
    .tbl_rdone      (tbl_rdone),
    .busy           (busy)
);

`default_nettype wire

// ### dv/switch_mac_addr_indirect_access_ctrl_tb.sv
// Self-checking bench of the station address and indirect access block
// Assumes the package and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none

module switch_mac_addr_indirect_access_ctrl_tb;
    import mac_ind_pkg::*;
    // Arbitrary reset values of the top address bytes
    localparam logic [7:0] B5 = 8'h4E;
    localparam logic [7:0] B4 = 8'h21;
    localparam logic [7:0] B3 = 8'hD7;
    logic        clock;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [47:0] station_address;
    logic        cmd_valid;
    logic        cmd_read;
    space_t      cmd_space;
    logic [1:0]  cmd_table;
    logic [3:0]  cmd_port;
    logic [11:0] cmd_addr;
    logic [71:0] cmd_wdata;
    logic        tbl_rdone;
    logic [71:0] tbl_rdata;
    logic        busy;
    int          num_errors;
    int          cmp_count;

    mac_ind_regs #(.SA_BYTE5_INIT(B5), .SA_BYTE4_INIT(B4), .SA_BYTE3_INIT(B3)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .station_address(station_address), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_space(cmd_space), .cmd_table(cmd_table), .cmd_port(cmd_port),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .tbl_rdone(tbl_rdone),
        .tbl_rdata(tbl_rdata), .busy(busy)
    );

    // ********
    // Bus and compare tasks
    // ********
    task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 chk($sformatf("reg %h", a), {64'h0, e}, {64'h0, reg_rdata});
    endtask

    // Control word, trigger, then ctrl1 read back with no gap
    task automatic cmd(input logic [7:0] c0, input logic [7:0] c1, input logic ev);
        wr(8'h6E, c0);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= 8'h6F;
        reg_wdata <= c1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        #1 chk("cmd_valid", {71'h0, ev}, {71'h0, cmd_valid});
        if (ev) begin
            chk("cmd_read", {71'h0, c0[4]}, {71'h0, cmd_read});
            chk("cmd_addr", {60'h0, c0[3:0], c1}, {60'h0, cmd_addr});
        end
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("ctrl1", {64'h0, c1}, {64'h0, reg_rdata});
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        logic [47:0] sa;
        sa = {B5, B4, B3, 24'hFFFFFF};
        chk("station_address", {24'h0, sa}, {24'h0, station_address});
        chk("cmd_space", {63'h0, SP_NONE}, {63'h0, cmd_space});
        for (int i = 0; i < 6; i++) rd(8'h68 + i[7:0], sa[47 - 8*i -: 8]);
        rd(8'h6F, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h80, 8'h5A);
        rd(8'h80, 8'h00);
    endtask

    task automatic t_station;
        logic [47:0] sa;
        sa = 48'hC15E0A937BE4;
        for (int i = 0; i < 6; i++) wr(8'h68 + i[7:0], sa[47 - 8*i -: 8]);
        repeat (2) @(posedge clock);
        #1 chk("station_address", {24'h0, sa}, {24'h0, station_address});
        for (int i = 0; i < 6; i++) rd(8'h68 + i[7:0], sa[47 - 8*i -: 8]);
    endtask

    task automatic t_funcs;
        logic [7:0] c0 [8] = '{8'h01, 8'h06, 8'h0B, 8'h0E, 8'h25, 8'h42, 8'h80, 8'hA3};
        space_t sp [8] = '{SP_STATIC, SP_VLAN, SP_DYN, SP_MIB, SP_EEE, SP_ACL, SP_PME,
                           SP_CABLE};
        for (int i = 0; i < 8; i++) begin
            cmd(c0[i], 8'hA5 ^ i[7:0], 1'b1);
            chk("cmd_space", {63'h0, sp[i]}, {63'h0, cmd_space});
            if (i < 4) chk("cmd_table", {70'h0, c0[i][3:2]}, {70'h0, cmd_table});
            else chk("cmd_port", {68'h0, c0[i][3:0]}, {68'h0, cmd_port});
        end
    endtask

    task automatic t_read;
        logic [71:0] d;
        logic [71:0] e;
        d = 72'h101112131415161718;
        e = ~d;
        for (int i = 0; i < 9; i++) wr(8'h70 + i[7:0], d[71 - 8*i -: 8]);
        cmd(8'h04, 8'h33, 1'b1);
        chk("cmd_wdata", d, cmd_wdata);
        cmd(8'h10, 8'h07, 1'b1);
        chk("busy", 72'h1, {71'h0, busy});
        cmd(8'h00, 8'h08, 1'b0);
        @(posedge clock);
        tbl_rdone <= 1'b1;
        tbl_rdata <= e;
        @(posedge clock);
        tbl_rdone <= 1'b0;
        #1 chk("busy", 72'h0, {71'h0, busy});
        for (int i = 0; i < 9; i++) rd(8'h70 + i[7:0], e[71 - 8*i -: 8]);
    endtask

    task automatic t_refuse;
        logic [7:0] c0 [5] = '{8'h60, 8'hC0, 8'hE0, 8'h23, 8'h44};
        for (int i = 0; i < 5; i++) cmd(c0[i], 8'h3C, 1'b0);
        rd(8'h70, 8'hEF);
    endtask

    task automatic final_report;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ********
    // Clock, watchdog and main sequence
    // ********
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        final_report();
    end

    initial begin
        num_errors = 0;
        cmp_count  = 0;
        rst_n      <= 1'b0;
        reg_addr   <= 8'h00;
        reg_wdata  <= 8'h00;
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b0;
        tbl_rdone  <= 1'b0;
        tbl_rdata  <= 72'h0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        #1 t_reset();
        t_station();
        t_funcs();
        t_read();
        t_refuse();
        final_report();
    end
endmodule

`default_nettype wire

// ### hdl/ind_cmd_decode.sv
// Decoder of the indirect command fields into space, table, port and address
// Assumes combinational use by the register block
`timescale 1ns/1ps
`default_nettype none
`include "mac_ind_params.svh"

module ind_cmd_decode (
    input  wire logic [7:0]         ctrl0,
    input  wire logic [7:0]         addr_low,
    output mac_ind_pkg::space_t     space,
    output logic      [1:0]         table_sel,
    output logic      [3:0]         port,
    output logic      [11:0]        addr,
    output logic                    legal
);
    import mac_ind_pkg::*;

    logic [2:0] func;
    logic       port_ok;

    // ****************************************
    // Field split
    // ****************************************
    always_comb begin
        func      = ctrl0[`FUNC_MSB:`FUNC_LSB];
        table_sel = ctrl0[`SEL_MSB:`SEL_LSB];
        addr      = {ctrl0[`ADDR_HI_MSB:`ADDR_HI_LSB], addr_low};
        port      = addr[`PORT_MSB:`PORT_LSB];
        port_ok   = (port == `PORT_GLOBAL) || (port == `PORT_ONE) ||
                    (port == `PORT_TWO) || (port == `PORT_FOUR);
    end

    // ****************************************
    // Space select
    // ****************************************
    always_comb begin
        space = SP_NONE;
        legal = 1'b1;
        case (func)
            `FUNC_TABLE: begin
                case (table_sel)
                    `TBL_STATIC: space = SP_STATIC;
                    `TBL_VLAN:   space = SP_VLAN;
                    `TBL_DYN:    space = SP_DYN;
                    default:     space = SP_MIB;
                endcase
            end
            `FUNC_EEE: begin
                space = SP_EEE;
                legal = port_ok;
            end
            `FUNC_ACL: begin
                space = SP_ACL;
                legal = port_ok;
            end
            `FUNC_PME:   space = SP_PME;
            `FUNC_CABLE: space = SP_CABLE;
            default: begin
                space = SP_NONE;
                legal = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### hdl/mac_ind_regs.sv
// Station address registers and indirect access control with data window
// Assumes a simple strobe register port and an outside table engine
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mac_ind_params.svh"

module mac_ind_regs #(
    // Arbitrary reset values for the top three address bytes
    parameter logic [7:0] SA_BYTE5_INIT = 8'h02,
    parameter logic [7:0] SA_BYTE4_INIT = 8'h3C,
    parameter logic [7:0] SA_BYTE3_INIT = 8'h96
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    output logic      [47:0]         station_address,
    output logic                     cmd_valid,
    output logic                     cmd_read,
    output mac_ind_pkg::space_t      cmd_space,
    output logic      [1:0]          cmd_table,
    output logic      [3:0]          cmd_port,
    output logic      [11:0]         cmd_addr,
    output logic      [71:0]         cmd_wdata,
    input  wire logic                tbl_rdone,
    input  wire logic [71:0]         tbl_rdata,
    output logic                     busy
);
    import mac_ind_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic   [7:0]   sa_ff [0:`NUM_SA-1];
    logic   [7:0]   data_ff [0:`NUM_DATA-1];
    logic   [7:0]   ctrl0_ff;
    logic   [7:0]   ctrl1_ff;
    logic   [7:0]   rdata_ff;
    logic   [7:0]   nxt_rdata;
    state_t         state_ff;
    state_t         nxt_state;
    logic           cmd_valid_ff;
    logic           cmd_read_ff;
    space_t         cmd_space_ff;
    logic   [1:0]   cmd_table_ff;
    logic   [3:0]   cmd_port_ff;
    logic   [11:0]  cmd_addr_ff;
    logic   [71:0]  cmd_wdata_ff;
    logic   [71:0]  data_word;
    logic   [47:0]  sa_word;
    logic           trigger;
    logic           accept;
    logic           load_rd;
    space_t         dec_space;
    logic   [1:0]   dec_table;
    logic   [3:0]   dec_port;
    logic   [11:0]  dec_addr;
    logic           dec_legal;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] word_byte(input logic [71:0] word, input int idx);
        logic [7:0] b;
        b = word[(`NUM_DATA-1-idx)*8 +: 8];
        return b;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ****************************************
    // Command decode
    // ****************************************
    ind_cmd_decode u_decode (
        .ctrl0     (ctrl0_ff),
        .addr_low  (reg_wdata),
        .space     (dec_space),
        .table_sel (dec_table),
        .port      (dec_port),
        .addr      (dec_addr),
        .legal     (dec_legal)
    );

    always_comb begin
        trigger = reg_wr && hit(reg_addr, `IND_CTRL1_OFS);
        accept  = trigger && dec_legal && (state_ff == ST_IDLE);
        load_rd = (state_ff == ST_WAIT) && tbl_rdone;
    end

    // ****************************************
    // Word assembly
    // ****************************************
    always_comb begin
        data_word = '0;
        for (int i = 0; i < `NUM_DATA; i++) begin
            data_word[(`NUM_DATA-1-i)*8 +: 8] = data_ff[i];
        end
    end

    always_comb begin
        sa_word = '0;
        for (int i = 0; i < `NUM_SA; i++) begin
            sa_word[(`NUM_SA-1-i)*8 +: 8] = sa_ff[i];
        end
    end

    // ****************************************
    // Station address bytes
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sa_ff[0] <= SA_BYTE5_INIT;
            sa_ff[1] <= SA_BYTE4_INIT;
            sa_ff[2] <= SA_BYTE3_INIT;
            sa_ff[3] <= `SA_LOW_RST;
            sa_ff[4] <= `SA_LOW_RST;
            sa_ff[5] <= `SA_LOW_RST;
        end else if (reg_wr) begin
            for (int i = 0; i < `NUM_SA; i++) begin
                if (hit(reg_addr, `SA_BYTE5_OFS + 8'(i))) begin
                    sa_ff[i] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            station_address <= {SA_BYTE5_INIT, SA_BYTE4_INIT, SA_BYTE3_INIT,
                                `SA_LOW_RST, `SA_LOW_RST, `SA_LOW_RST};
        end else begin
            station_address <= sa_word;
        end
    end

    // ****************************************
    // Indirect control registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff <= `CTRL_RST;
        end else if (reg_wr && hit(reg_addr, `IND_CTRL0_OFS)) begin
            ctrl0_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= `CTRL_RST;
        end else if (trigger) begin
            ctrl1_ff <= reg_wdata;
        end
    end

    // ****************************************
    // Indirect data window
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `NUM_DATA; i++) begin
                data_ff[i] <= `DATA_RST;
            end
        end else if (load_rd) begin
            for (int i = 0; i < `NUM_DATA; i++) begin
                data_ff[i] <= word_byte(tbl_rdata, i);
            end
        end else if (reg_wr) begin
            for (int i = 0; i < `NUM_DATA; i++) begin
                if (hit(reg_addr, `IND_DATA_FIRST + 8'(i))) begin
                    data_ff[i] <= reg_wdata;
                end
            end
        end
    end

    // ****************************************
    // Command sequencing
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept && ctrl0_ff[`DIR_BIT]) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tbl_rdone) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (nxt_state == ST_WAIT);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid_ff <= 1'b0;
        end else begin
            cmd_valid_ff <= accept;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_read_ff  <= 1'b0;
            cmd_space_ff <= SP_NONE;
            cmd_table_ff <= 2'h0;
            cmd_port_ff  <= 4'h0;
            cmd_addr_ff  <= 12'h000;
            cmd_wdata_ff <= 72'h0;
        end else if (accept) begin
            cmd_read_ff  <= ctrl0_ff[`DIR_BIT];
            cmd_space_ff <= dec_space;
            cmd_table_ff <= dec_table;
            cmd_port_ff  <= dec_port;
            cmd_addr_ff  <= dec_addr;
            cmd_wdata_ff <= data_word;
        end
    end

    always_comb begin
        cmd_valid = cmd_valid_ff;
        cmd_read  = cmd_read_ff;
        cmd_space = cmd_space_ff;
        cmd_table = cmd_table_ff;
        cmd_port  = cmd_port_ff;
        cmd_addr  = cmd_addr_ff;
        cmd_wdata = cmd_wdata_ff;
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        nxt_rdata = `READ_ZERO;
        for (int i = 0; i < `NUM_SA; i++) begin
            if (hit(reg_addr, `SA_BYTE5_OFS + 8'(i))) begin
                nxt_rdata = sa_ff[i];
            end
        end
        for (int i = 0; i < `NUM_DATA; i++) begin
            if (hit(reg_addr, `IND_DATA_FIRST + 8'(i))) begin
                nxt_rdata = data_ff[i];
            end
        end
        if (hit(reg_addr, `IND_CTRL0_OFS)) begin
            nxt_rdata = ctrl0_ff;
        end
        if (hit(reg_addr, `IND_CTRL1_OFS)) begin
            nxt_rdata = ctrl1_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `READ_ZERO;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= `READ_ZERO;
        end
    end

    always_comb begin
        reg_rdata = rdata_ff;
    end

endmodule
`default_nettype wire

// ### inc/mac_ind_params.svh
// Constants for the station address and indirect access control block
// Assumes inclusion by bare name from the design files
`ifndef MAC_IND_PARAMS_SVH
`define MAC_IND_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SA_BYTE5_OFS    8'h68
`define SA_BYTE4_OFS    8'h69
`define SA_BYTE3_OFS    8'h6A
`define SA_BYTE2_OFS    8'h6B
`define SA_BYTE1_OFS    8'h6C
`define SA_BYTE0_OFS    8'h6D
`define IND_CTRL0_OFS   8'h6E
`define IND_CTRL1_OFS   8'h6F
`define IND_DATA_FIRST  8'h70
`define IND_DATA_LAST   8'h78

// ****************************************
// Field positions
// ****************************************
`define FUNC_MSB        7
`define FUNC_LSB        5
`define DIR_BIT         4
`define SEL_MSB         3
`define SEL_LSB         2
`define ADDR_HI_MSB     3
`define ADDR_HI_LSB     0
`define PORT_MSB        11
`define PORT_LSB        8

// ****************************************
// Encodings
// ****************************************
`define FUNC_TABLE      3'h0
`define FUNC_EEE        3'h1
`define FUNC_ACL        3'h2
`define FUNC_RSVD       3'h3
`define FUNC_PME        3'h4
`define FUNC_CABLE      3'h5
`define TBL_STATIC      2'h0
`define TBL_VLAN        2'h1
`define TBL_DYN         2'h2
`define TBL_MIB         2'h3
`define PORT_GLOBAL     4'h0
`define PORT_ONE        4'h1
`define PORT_TWO        4'h2
`define PORT_FOUR       4'h5

// ****************************************
// Reset values and counts
// ****************************************
`define SA_LOW_RST      8'hFF
`define CTRL_RST        8'h00
`define DATA_RST        8'h00
`define READ_ZERO       8'h00
`define NUM_DATA        9
`define NUM_SA          6

`endif

// ### inc/mac_ind_pkg.sv
// Types for the station address and indirect access control block
// Assumes compilation before the design modules
package mac_ind_pkg;

    typedef enum logic [8:0] {
        SP_NONE   = 9'h001,
        SP_STATIC = 9'h002,
        SP_VLAN   = 9'h004,
        SP_DYN    = 9'h008,
        SP_MIB    = 9'h010,
        SP_EEE    = 9'h020,
        SP_ACL    = 9'h040,
        SP_PME    = 9'h080,
        SP_CABLE  = 9'h100
    } space_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_WAIT = 2'h2
    } state_t;

endpackage
